//--- fir_pkg.sv
// fir_pkg: constants, types and helpers of the fault reporting block
// assumes: core clock ref_clk at 20 MHz, serial link clocked by the host
`default_nettype none

package fir_pkg;
  // register map
  localparam logic [6:0] ADDR_SUM  = 7'h50;
  localparam logic [6:0] ADDR_WAKE = 7'h51;
  localparam logic [6:0] ADDR_SUP  = 7'h52;
  localparam logic [6:0] ADDR_SERR = 7'h53;
  localparam logic [6:0] ADDR_BUS  = 7'h54;
  // summary fields
  localparam int SUM_ANY  = 7;
  localparam int SUM_WAKE = 6;
  localparam int SUM_SUP  = 5;
  localparam int SUM_SERR = 4;
  localparam int SUM_BUS  = 3;
  // wake and watchdog fields
  localparam int WAKE_WD     = 7;
  localparam int WAKE_BUSW   = 6;
  localparam int WAKE_LOCAL  = 5;
  localparam int WAKE_ERR    = 4;
  localparam int WAKE_SILENT = 2;
  localparam int WAKE_DOM    = 0;
  localparam logic [7:0] WAKE_MASK = 8'hf5;
  // serial error field
  localparam int SERR_BIT = 7;
  localparam logic [7:0] SERR_MASK = 8'h80;
  // reset values
  localparam logic [7:0] RST_SUM  = 8'h00;
  localparam logic [7:0] RST_WAKE = 8'h00;
  localparam logic [7:0] RST_SERR = 8'h00;
  // frame layout
  localparam int WR_BIT = 15;
  localparam logic [4:0] FRAME_FULL  = 5'h10;
  localparam logic [4:0] FRAME_SHORT = 5'h08;
  localparam logic [4:0] CNT_MAX     = 5'h1f;
  // trim memory and check
  localparam int TRIM_AW = 4;
  localparam int TRIM_DEPTH = 16;
  localparam logic [3:0] TRIM_LAST = 4'hf;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // thermal release time
  localparam int CLK_PERIOD_NS = 50;
  localparam int TSD_RELEASE_NS = 800;
  localparam logic [4:0] TSD_RELEASE_CYC =
    5'((TSD_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {CRC_IDLE, CRC_ISSUE, CRC_ACC} fir_crc_st_t;

  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
endpackage

`default_nettype wire

//--- fir_trim_mem.sv
// fir_trim_mem: trim word store, one write port, registered read
// assumes: single clock, synchronous active high reset
`timescale 1ns/10ps
`default_nettype none

module fir_trim_mem import fir_pkg::*; (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // write port
  input  wire logic               we,
  input  wire logic [TRIM_AW-1:0] waddr,
  input  wire logic [7:0]         wdata,
  // read port
  input  wire logic [TRIM_AW-1:0] raddr,
  output logic      [7:0]         rdata
);
  logic [7:0] mem_q [TRIM_DEPTH];

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < TRIM_DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem_q[raddr];
    end
  end
endmodule

`default_nettype wire

//--- fir_spi_link.sv
// fir_spi_link: serial shifter on the host clock, data change on rising, sample on falling
// assumes: snapshot words stay still while chip select is low
`timescale 1ns/10ps
`default_nettype none

module fir_spi_link import fir_pkg::*; (
  // core reset, released while the serial clock is idle
  input  wire logic        rst,
  // serial pins
  input  wire logic        sclk,
  input  wire logic        chip_select_low,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe_n,
  // frozen register images
  input  wire logic [7:0]  snap_sum,
  input  wire logic [7:0]  snap_wake,
  input  wire logic [7:0]  snap_sup,
  input  wire logic [7:0]  snap_serr,
  input  wire logic [7:0]  snap_bus,
  // frame result, still after the frame
  output logic [4:0]       frame_cnt,
  output logic [15:0]      frame_word,
  output logic             frame_seq
);
  logic       fresh_q;
  logic [6:0] addr_q;
  logic [4:0] bit_idx;
  logic [7:0] rd_byte;

  assign bit_idx = fresh_q ? 5'h00 : frame_cnt;

  // frame start marker
  always_ff @(negedge sclk or posedge chip_select_low or posedge rst) begin
    if (rst || chip_select_low) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // input shifting and bit count
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      frame_word <= 16'h0000;
      frame_cnt  <= 5'h00;
      frame_seq  <= 1'b0;
      addr_q     <= 7'h00;
    end else if (!chip_select_low) begin
      frame_word <= {frame_word[14:0], sdi};
      if (fresh_q) begin
        frame_cnt <= 5'h01;
        frame_seq <= ~frame_seq;
      end else if (frame_cnt != CNT_MAX) begin
        frame_cnt <= frame_cnt + 5'h01;
      end
      if (!fresh_q && frame_cnt == 5'h07) begin
        addr_q <= {frame_word[5:0], sdi};
      end
    end
  end

  always_comb begin
    if (addr_q == ADDR_SUM) begin
      rd_byte = snap_sum;
    end else if (addr_q == ADDR_WAKE) begin
      rd_byte = snap_wake;
    end else if (addr_q == ADDR_SUP) begin
      rd_byte = snap_sup;
    end else if (addr_q == ADDR_SERR) begin
      rd_byte = snap_serr;
    end else if (addr_q == ADDR_BUS) begin
      rd_byte = snap_bus;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // output bit, summary first
  always_ff @(posedge sclk or posedge chip_select_low) begin
    if (chip_select_low) begin
      sdo <= 1'b0;
    end else if (bit_idx < FRAME_SHORT) begin
      sdo <= snap_sum[~bit_idx[2:0]];
    end else if (bit_idx < FRAME_FULL) begin
      sdo <= rd_byte[~bit_idx[2:0]];
    end else begin
      sdo <= 1'b0;
    end
  end

  always_ff @(posedge sclk or posedge chip_select_low) begin
    if (chip_select_low) begin
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_oe_n <= 1'b0;
    end
  end

  property p_sum_out;
    @(negedge sclk) disable iff (chip_select_low)
      bit_idx < FRAME_SHORT |-> sdo == snap_sum[~bit_idx[2:0]];
  endproperty
  a_sum_out: assert property (p_sum_out) else $error("summary bit wrong");

  property p_oe;
    @(negedge sclk) disable iff (chip_select_low) 1'b1 |-> !sdo_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("output not driven in frame");
endmodule

`default_nettype wire

//--- fir_top.sv
// fir_top: fault flag registers, summary, thermal fail-safe and trim check
// assumes: host keeps chip select low 250 ns before the first clock edge
`timescale 1ns/10ps
`default_nettype none

module fir_top import fir_pkg::*; (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // serial link
  input  wire logic       sclk,
  input  wire logic       chip_select_low,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe_n,
  // event pins
  input  wire logic       watchdog_event,
  input  wire logic       bus_wake_in,
  input  wire logic       local_wake_in,
  input  wire logic       sleep_wake_error_timer,
  input  wire logic       bus_silent_in,
  input  wire logic       bus_stuck_dom_in,
  input  wire logic       over_temp,
  // other flag groups, core clock
  input  wire logic [7:0] supply_group_flags,
  input  wire logic [7:0] bus_fault_group,
  input  wire logic       spi_status_event,
  // trim programming and check
  input  wire logic       trim_wr,
  input  wire logic [3:0] trim_addr,
  input  wire logic [7:0] trim_wdata,
  input  wire logic       crc_start,
  // status
  output logic [7:0]      fault_summary,
  output logic [7:0]      supply_clear,
  output logic [7:0]      bus_fault_clear,
  output logic            tx_disable,
  output logic            thermal_failsafe,
  output logic            trim_crc_ok,
  output logic            trim_crc_err,
  output logic            crc_busy
);
  logic [6:0]  pin_s1_q, pin_s2_q, pin_s3_q;
  logic [6:0]  ev_rise;
  logic        cs_s1_q, cs_s2_q, cs_s3_q;
  logic        seen_q;
  logic [4:0]  lk_cnt;
  logic [15:0] lk_word;
  logic        lk_seq;
  logic [7:0]  wake_q, wake_d, wake_set, wake_clr;
  logic [7:0]  serr_q, serr_d, serr_clr;
  logic [7:0]  sum_q, sum_d;
  logic [7:0]  snap_sum_q, snap_wake_q, snap_sup_q, snap_serr_q, snap_bus_q;
  logic        frame_end, wr, bad_len, bad_wr, serr_set;
  logic [6:0]  waddr;
  logic [7:0]  wdata;
  logic [7:0]  sup_clr_q, bus_clr_q;
  logic        fs_q, tx_dis_q;
  logic [4:0]  rel_cnt_q;
  fir_crc_st_t crc_st_q;
  logic [3:0]  crc_addr_q;
  logic [7:0]  crc_acc_q, mem_rdata;
  logic        crc_ok_q, crc_err_q, pend_q;

  // pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_s1_q <= 7'h00;
      pin_s2_q <= 7'h00;
      pin_s3_q <= 7'h00;
    end else begin
      pin_s1_q <= {over_temp, bus_stuck_dom_in, bus_silent_in, sleep_wake_error_timer,
                   local_wake_in, bus_wake_in, watchdog_event};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign ev_rise = pin_s2_q & ~pin_s3_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= chip_select_low;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end

  fir_spi_link u_link (
    .rst             (rst),
    .sclk            (sclk),
    .chip_select_low (chip_select_low),
    .sdi             (sdi),
    .sdo             (sdo),
    .sdo_oe_n        (sdo_oe_n),
    .snap_sum        (snap_sum_q),
    .snap_wake       (snap_wake_q),
    .snap_sup        (snap_sup_q),
    .snap_serr       (snap_serr_q),
    .snap_bus        (snap_bus_q),
    .frame_cnt       (lk_cnt),
    .frame_word      (lk_word),
    .frame_seq       (lk_seq)
  );

  // frame decode once chip select is back high
  always_comb begin
    frame_end = cs_s2_q & ~cs_s3_q & (lk_seq != seen_q);
    waddr     = lk_word[14:8];
    wdata     = lk_word[7:0];
    wr        = frame_end & (lk_cnt == FRAME_FULL) & lk_word[WR_BIT];
    bad_len   = frame_end & (lk_cnt != FRAME_FULL) & (lk_cnt != FRAME_SHORT);
    bad_wr    = wr & ((waddr < ADDR_WAKE) | (waddr > ADDR_BUS));
    serr_set  = bad_len | bad_wr | spi_status_event;
    wake_clr  = (wr && waddr == ADDR_WAKE) ? wdata : 8'h00;
    serr_clr  = (wr && waddr == ADDR_SERR) ? wdata : 8'h00;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seen_q <= 1'b0;
    end else if (frame_end) begin
      seen_q <= lk_seq;
    end
  end

  // wake and watchdog flags, set wins over clear
  always_comb begin
    wake_set = 8'h00;
    wake_set[WAKE_WD]     = ev_rise[0];
    wake_set[WAKE_BUSW]   = ev_rise[1];
    wake_set[WAKE_LOCAL]  = ev_rise[2];
    wake_set[WAKE_ERR]    = ev_rise[3];
    wake_set[WAKE_SILENT] = ev_rise[4];
    wake_set[WAKE_DOM]    = ev_rise[5];
    wake_d = ((wake_q & ~wake_clr) | wake_set) & WAKE_MASK;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_q <= RST_WAKE;
    end else begin
      wake_q <= wake_d;
    end
  end

  // serial error flag
  always_comb begin
    serr_d = serr_q & ~serr_clr;
    serr_d[SERR_BIT] = serr_d[SERR_BIT] | serr_set;
    serr_d = serr_d & SERR_MASK;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serr_q <= RST_SERR;
    end else begin
      serr_q <= serr_d;
    end
  end

  // clear strobes to the supply and bus fault groups
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sup_clr_q <= 8'h00;
      bus_clr_q <= 8'h00;
    end else begin
      sup_clr_q <= (wr && waddr == ADDR_SUP) ? wdata : 8'h00;
      bus_clr_q <= (wr && waddr == ADDR_BUS) ? wdata : 8'h00;
    end
  end

  // summary
  always_comb begin
    sum_d = 8'h00;
    sum_d[SUM_WAKE] = |wake_q;
    sum_d[SUM_SUP]  = |supply_group_flags;
    sum_d[SUM_SERR] = |serr_q;
    sum_d[SUM_BUS]  = |bus_fault_group;
    sum_d[SUM_ANY]  = |{wake_q, supply_group_flags, serr_q, bus_fault_group};
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sum_q <= RST_SUM;
    end else begin
      sum_q <= sum_d;
    end
  end

  // images frozen for the link while chip select is low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      snap_sum_q  <= RST_SUM;
      snap_wake_q <= RST_WAKE;
      snap_sup_q  <= 8'h00;
      snap_serr_q <= RST_SERR;
      snap_bus_q  <= 8'h00;
    end else if (cs_s2_q) begin
      snap_sum_q  <= sum_q;
      snap_wake_q <= wake_q;
      snap_sup_q  <= supply_group_flags;
      snap_serr_q <= serr_q;
      snap_bus_q  <= bus_fault_group;
    end
  end

  // thermal fail-safe with release delay
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fs_q      <= 1'b0;
      rel_cnt_q <= 5'h00;
    end else if (pin_s2_q[6]) begin
      fs_q      <= 1'b1;
      rel_cnt_q <= TSD_RELEASE_CYC;
    end else if (rel_cnt_q != 5'h00) begin
      rel_cnt_q <= rel_cnt_q - 5'h01;
    end else begin
      fs_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tx_dis_q <= 1'b0;
    end else begin
      tx_dis_q <= pin_s2_q[6] | fs_q;
    end
  end

  // trim check
  fir_trim_mem u_mem (
    .clk   (ref_clk),
    .rst   (rst),
    .we    (trim_wr && crc_st_q == CRC_IDLE),
    .waddr (trim_addr),
    .wdata (trim_wdata),
    .raddr (crc_addr_q),
    .rdata (mem_rdata)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      crc_st_q   <= CRC_IDLE;
      crc_addr_q <= 4'h0;
      crc_acc_q  <= CRC_INIT;
      crc_ok_q   <= 1'b0;
      crc_err_q  <= 1'b0;
      pend_q     <= 1'b1;
    end else begin
      case (crc_st_q)
        CRC_IDLE: begin
          if (pend_q || crc_start) begin
            crc_st_q   <= CRC_ISSUE;
            crc_addr_q <= 4'h0;
            crc_acc_q  <= CRC_INIT;
            pend_q     <= 1'b0;
          end
        end
        CRC_ISSUE: begin
          crc_st_q <= CRC_ACC;
        end
        CRC_ACC: begin
          if (crc_addr_q == TRIM_LAST) begin
            crc_ok_q  <= (crc_acc_q == mem_rdata);
            crc_err_q <= (crc_acc_q != mem_rdata);
            crc_st_q  <= CRC_IDLE;
          end else begin
            crc_acc_q  <= crc8_byte(crc_acc_q, mem_rdata);
            crc_addr_q <= crc_addr_q + 4'h1;
            crc_st_q   <= CRC_ISSUE;
          end
        end
        default: begin
          crc_st_q <= CRC_IDLE;
        end
      endcase
    end
  end

  assign fault_summary    = sum_q;
  assign supply_clear     = sup_clr_q;
  assign bus_fault_clear  = bus_clr_q;
  assign tx_disable       = tx_dis_q;
  assign thermal_failsafe = fs_q;
  assign trim_crc_ok      = crc_ok_q;
  assign trim_crc_err     = crc_err_q;
  assign crc_busy         = (crc_st_q != CRC_IDLE);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_pin_rise(int k);
    !pin_s2_q[k] ##1 pin_s2_q[k];
  endsequence

  property p_sum_rst;
    @(posedge ref_clk) disable iff (1'b0) rst |=> sum_q == RST_SUM;
  endproperty
  a_sum_rst: assert property (p_sum_rst) else $error("summary not zero after reset");
  property p_any;
    1'b1 |=> sum_q[SUM_ANY] == $past(|{wake_q, supply_group_flags, serr_q, bus_fault_group});
  endproperty
  a_any: assert property (p_any) else $error("any fault bit wrong");
  property p_grp_wake;
    1'b1 |=> sum_q[SUM_WAKE] == $past(|wake_q);
  endproperty
  a_grp_wake: assert property (p_grp_wake) else $error("wake group bit wrong");
  property p_grp_sup;
    1'b1 |=> sum_q[SUM_SUP] == $past(|supply_group_flags);
  endproperty
  a_grp_sup: assert property (p_grp_sup) else $error("supply group bit wrong");
  property p_grp_serr;
    1'b1 |=> sum_q[SUM_SERR] == $past(serr_q[SERR_BIT]);
  endproperty
  a_grp_serr: assert property (p_grp_serr) else $error("serial group bit wrong");
  property p_grp_bus;
    1'b1 |=> sum_q[SUM_BUS] == $past(|bus_fault_group) && sum_q[2:0] == 3'h0;
  endproperty
  a_grp_bus: assert property (p_grp_bus) else $error("bus group bit wrong");
  property p_w1c;
    wake_clr[WAKE_DOM] && !wake_set[WAKE_DOM] |=> !wake_q[WAKE_DOM] && wake_q[3] == 1'b0;
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared by one");
  property p_keep;
    wr && waddr == ADDR_WAKE && !wdata[WAKE_SILENT] && wake_q[WAKE_SILENT]
      |=> wake_q[WAKE_SILENT] ##1 sum_q[SUM_WAKE];
  endproperty
  a_keep: assert property (p_keep) else $error("zero write changed a flag");
  property p_wd;
    s_pin_rise(0) |=> wake_q[WAKE_WD];
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog flag not set");
  property p_wake;
    s_pin_rise(1) or s_pin_rise(2) |=> wake_q[WAKE_BUSW] || wake_q[WAKE_LOCAL];
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag not set");
  property p_wake_error_flag;
    s_pin_rise(3) |=> wake_q[WAKE_ERR];
  endproperty
  a_wake_error_flag: assert property (p_wake_error_flag) else $error("wake error flag not set");
  property p_dom;
    s_pin_rise(5) |=> wake_q[WAKE_DOM];
  endproperty
  a_dom: assert property (p_dom) else $error("stuck dominant flag not set");
  property p_tsd;
    pin_s2_q[6] |=> tx_dis_q && fs_q;
  endproperty
  a_tsd: assert property (p_tsd) else $error("transmitter not disabled");
  property p_crc;
    crc_st_q == CRC_ACC && crc_addr_q == TRIM_LAST && crc_acc_q != mem_rdata
      |=> crc_err_q && !crc_ok_q;
  endproperty
  a_crc: assert property (p_crc) else $error("trim check miss");
  property p_serr;
    serr_set |=> serr_q[SERR_BIT] ##1 sum_q[SUM_SERR];
  endproperty
  a_serr: assert property (p_serr) else $error("serial error flag not set");
endmodule

`default_nettype wire

//--- fir_host_model.sv
// fir_host_model: host serial controller driving the fault block's link
// assumes: link clock 6 ns period, stands low outside frames
`timescale 1ns/10ps
`default_nettype none

module fir_host_model (
  // serial pins
  output var logic sclk,
  output var logic chip_select_low,
  output var logic sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  initial begin
    sclk = 1'b0;
    chip_select_low = 1'b1;
    sdi = 1'b0;
  end

  // one frame of n bits, msb first, tx from bit 15 down, rx into [n-1:0]
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    #7 chip_select_low = 1'b0;
    #250;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      sdi = tx[15-i];
      #3 sclk = 1'b0;
      rx[n-1-i] = (sdo_oe_n === 1'b0) ? sdo : 1'bx;
      #3;
    end
    chip_select_low = 1'b1;
    sdi = ~sdi;
    #300;
  endtask
endmodule

`default_nettype wire

//--- tb_top.sv
// tb_top: self-checking bench of the fault reporting block
// assumes: fir_host_model drives the link, bench drives core inputs
`timescale 1ns/10ps
`default_nettype none

module tb_top import fir_pkg::*;;
  logic ref_clk, rst, sclk, chip_select_low, sdi, sdo, sdo_oe_n;
  logic [5:0] ev;
  logic over_temp, spi_status_event, trim_wr, crc_start;
  logic [7:0] supply_group_flags, bus_fault_group, trim_wdata, fault_summary;
  logic [7:0] supply_clear, bus_fault_clear, sc_seen, bc_seen;
  logic [3:0] trim_addr;
  logic tx_disable, thermal_failsafe, trim_crc_ok, trim_crc_err, crc_busy;
  logic [15:0] rx;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;

  fir_host_model fir_host_model_inst (.sclk(sclk), .chip_select_low(chip_select_low),
    .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));

  fir_top fir_top_inst (.ref_clk(ref_clk), .rst(rst), .sclk(sclk),
    .chip_select_low(chip_select_low), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
    .watchdog_event(ev[5]), .bus_wake_in(ev[4]), .local_wake_in(ev[3]),
    .sleep_wake_error_timer(ev[2]), .bus_silent_in(ev[1]), .bus_stuck_dom_in(ev[0]),
    .over_temp(over_temp), .supply_group_flags(supply_group_flags),
    .bus_fault_group(bus_fault_group), .spi_status_event(spi_status_event),
    .trim_wr(trim_wr), .trim_addr(trim_addr), .trim_wdata(trim_wdata),
    .crc_start(crc_start), .fault_summary(fault_summary), .supply_clear(supply_clear),
    .bus_fault_clear(bus_fault_clear), .tx_disable(tx_disable),
    .thermal_failsafe(thermal_failsafe), .trim_crc_ok(trim_crc_ok),
    .trim_crc_err(trim_crc_err), .crc_busy(crc_busy));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // capture of the one-cycle clear pulses
  always @(posedge ref_clk) begin
    if (rst) begin
      sc_seen <= 8'h00;
      bc_seen <= 8'h00;
    end else begin
      if (supply_clear !== 8'h00) sc_seen <= supply_clear;
      if (bus_fault_clear !== 8'h00) bc_seen <= bus_fault_clear;
    end
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  function automatic logic [7:0] mk_sum(input logic [7:0] w, s, e, b);
    return {|{w, s, e, b}, |w, |s, |e, |b, 3'b000};
  endfunction

  function automatic logic [7:0] crc_ref(input logic [7:0] w0);
    logic [7:0] c;
    c = w0;
    for (int k = 0; k < 120; k++) c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
    return c;
  endfunction

  task automatic rd(input logic [6:0] a, input logic [7:0] reg_exp, input logic [7:0] sum_exp);
    fir_host_model_inst.xfer({1'b0, a, 8'h00}, 16, rx);
    tick(1);
    check("summary byte", {8'h00, rx[15:8]}, {8'h00, sum_exp});
    check("register byte", {8'h00, rx[7:0]}, {8'h00, reg_exp});
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    fir_host_model_inst.xfer({1'b1, a, d}, 16, rx);
    tick(8);
  endtask

  task automatic t_reset();
    check("summary at reset", {8'h00, fault_summary}, {8'h00, RST_SUM});
    tick(40);
    check("crc ok at reset", {15'h0, trim_crc_ok}, 16'h0001);
    rd(ADDR_WAKE, RST_WAKE, RST_SUM);
  endtask

  task automatic t_events();
    logic [7:0] bits [6];
    logic [7:0] acc;
    bits = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h04, 8'h01};
    acc = 8'h00;
    for (int i = 0; i < 6; i++) begin
      ev[5-i] <= 1'b1;
      tick(3);
      ev[5-i] <= 1'b0;
      tick(6);
      acc = acc | bits[i];
      check("summary wake", {8'h00, fault_summary}, {8'h00, mk_sum(acc, 0, 0, 0)});
      rd(ADDR_WAKE, acc, mk_sum(acc, 0, 0, 0));
    end
    wr(ADDR_WAKE, 8'h0a);
    rd(ADDR_WAKE, 8'hf5, mk_sum(8'hf5, 0, 0, 0));
    wr(ADDR_WAKE, 8'h80);
    rd(ADDR_WAKE, 8'h75, mk_sum(8'h75, 0, 0, 0));
    wr(ADDR_WAKE, 8'h75);
    rd(ADDR_WAKE, 8'h00, 8'h00);
    ev[5] <= 1'b1;
    tick(3);
    ev[5] <= 1'b0;
    tick(6);
    rd(ADDR_WAKE, 8'h80, 8'hc0);
    wr(ADDR_WAKE, 8'h80);
  endtask

  task automatic t_groups();
    supply_group_flags <= 8'h40;
    tick(4);
    check("summary supply", {8'h00, fault_summary}, 16'h00a0);
    bus_fault_group <= 8'h21;
    tick(4);
    check("summary bus", {8'h00, fault_summary}, 16'h00a8);
    wr(ADDR_SUP, 8'h40);
    check("supply clear", {8'h00, sc_seen}, 16'h0040);
    wr(ADDR_BUS, 8'h21);
    check("bus clear", {8'h00, bc_seen}, 16'h0021);
    supply_group_flags <= 8'h00;
    bus_fault_group <= 8'h00;
    tick(4);
    check("summary dropped", {8'h00, fault_summary}, 16'h0000);
  endtask

  task automatic t_serial();
    fir_host_model_inst.xfer(16'h5100, 12, rx);
    tick(8);
    check("summary serial", {8'h00, fault_summary}, 16'h0090);
    rd(ADDR_SERR, SERR_MASK, 8'h90);
    wr(ADDR_SERR, 8'h80);
    rd(ADDR_SERR, 8'h00, 8'h00);
    wr(ADDR_SUM, 8'hff);
    check("summary read only", {8'h00, fault_summary}, 16'h0090);
    fir_host_model_inst.xfer(16'h0000, 8, rx);
    tick(1);
    check("short frame", rx, 16'h0090);
    wr(ADDR_SERR, 8'h80);
    spi_status_event <= 1'b1;
    tick(1);
    spi_status_event <= 1'b0;
    tick(4);
    check("status event", {8'h00, fault_summary}, 16'h0090);
    wr(ADDR_SERR, 8'h80);
    check("serial cleared", {8'h00, fault_summary}, 16'h0000);
  endtask

  task automatic t_thermal();
    over_temp <= 1'b1;
    tick(5);
    check("tx off", {14'h0, tx_disable, thermal_failsafe}, 16'h0003);
    over_temp <= 1'b0;
    tick(10);
    check("tx held off", {15'h0, tx_disable}, 16'h0001);
    tick(16);
    check("tx back on", {14'h0, tx_disable, thermal_failsafe}, 16'h0000);
  endtask

  task automatic t_trim(input logic [3:0] a, input logic [7:0] d, input logic ok);
    trim_addr <= a;
    trim_wdata <= d;
    trim_wr <= 1'b1;
    tick(1);
    trim_wr <= 1'b0;
    crc_start <= 1'b1;
    tick(1);
    crc_start <= 1'b0;
    tick(3);
    check("crc busy", {15'h0, crc_busy}, 16'h0001);
    tick(40);
    check("crc result", {14'h0, trim_crc_ok, trim_crc_err}, {14'h0, ok, ~ok});
  endtask

  initial begin
    rst = 1'b1;
    ev = 6'h00;
    over_temp = 1'b0;
    spi_status_event = 1'b0;
    trim_wr = 1'b0;
    crc_start = 1'b0;
    trim_addr = 4'h0;
    trim_wdata = 8'h00;
    supply_group_flags = 8'h00;
    bus_fault_group = 8'h00;
    tick(4);
    rst <= 1'b0;
    t_reset();
    t_events();
    t_groups();
    t_serial();
    t_thermal();
    t_trim(4'h0, 8'h5a, 1'b0);
    t_trim(TRIM_LAST, crc_ref(8'h5a), 1'b1);
    stop_test();
  end
endmodule

`default_nettype wire
